// [hdl/arp_readout_port.sv]
// arp_readout_port: result readout port of a 16-bit converter, with
// parallel and serial (master or slave clocked) output and avalon setup.
// assumes sample_data is settled on sys_clk when a conversion ends and
// that all host pins are asynchronous; the pad ring resolves d_out/d_oe.
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
module arp_readout_port
    import arp_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES,  // conversion length, cycles
    parameter int ERR_LEN  = ERR_CYCLES    // overrun pulse, cycles
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // avalon-mm register slave
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // converter core result
    input  wire logic [RES_W-1:0] sample_data,
    // host pins
    input  wire logic             conversion_start_n,
    input  wire logic             cs_n,
    input  wire logic             rd_n,
    input  wire logic             link_sclk_in,
    output logic                  busy,
    output logic      [RES_W-1:0] d_out,
    output logic      [RES_W-1:0] d_oe
);

    // counter widths derived from the lengths
    localparam int CW = $clog2(CONV_LEN + 1);
    localparam int EW = $clog2(ERR_LEN + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_LEN - 1);
    localparam logic [EW-1:0] ERR_LOAD  = EW'(ERR_LEN);

    // result coding: two's complement is straight binary with msb flipped
    function automatic logic [RES_W-1:0] code_result(
        input logic [RES_W-1:0] raw,
        input logic             twos
    );
        code_result = twos ? {~raw[RES_W-1], raw[RES_W-2:0]} : raw;
    endfunction

    // one clock edge of the chosen polarity on a sampled clock level
    function automatic logic clk_edge(
        input logic prev,
        input logic now,
        input logic falling
    );
        clk_edge = falling ? (prev & ~now) : (~prev & now);
    endfunction

    // pin synchronisation
    logic [3:0] pin_raw;   // start, select, read, serial clock
    logic [3:0] pin_sync;  // same, two flops later
    logic       s_cnv_n;   // synced conversion start
    logic       s_cs_n;    // synced converter select
    logic       s_rd_n;    // synced read
    logic       s_sclk;    // synced external serial clock

    assign pin_raw = {conversion_start_n, cs_n, rd_n, link_sclk_in};

    // idle levels at reset: start, select and read high, clock low
    arp_sync #(
        .W       (4),
        .RST_VAL (4'hE)
    ) u_sync (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .async_in (pin_raw),
        .sync_out (pin_sync)
    );

    assign s_cnv_n = pin_sync[3];
    assign s_cs_n  = pin_sync[2];
    assign s_rd_n  = pin_sync[1];
    assign s_sclk  = pin_sync[0];

    // state of all groups
    logic             ack;          // avalon answer cycle
    logic             next_ack;
    logic [31:0]      rdata;        // registered read data
    logic [31:0]      next_rdata;
    arp_cfg_t         cfg;          // software configuration
    arp_cfg_t         next_cfg;
    logic [DIV_W-1:0] div;          // master clock quarter length - 1
    logic [DIV_W-1:0] next_div;
    logic [31:0]      status_word;  // live status view

    logic             next_busy;
    logic [CW-1:0]    conv_cnt;     // cycles left in the conversion
    logic [CW-1:0]    next_conv_cnt;
    logic [RES_W-1:0] result;       // coded result of last conversion
    logic [RES_W-1:0] next_result;
    logic             cnv_prev;     // start level one cycle ago
    logic             conv_done;    // one-cycle pulse at latch
    logic             next_conv_done;

    arp_rd_state_t    state;        // serial read sequencer
    arp_rd_state_t    next_state;
    arp_cfg_t         cfg_act;      // configuration of current read
    arp_cfg_t         next_cfg_act;
    logic [RES_W-1:0] shreg;        // output shift register
    logic [RES_W-1:0] next_shreg;
    logic [3:0]       bit_cnt;      // bits already sent
    logic [3:0]       next_bit_cnt;
    logic [DIV_W-1:0] div_cnt;      // cycles inside a quarter
    logic [DIV_W-1:0] next_div_cnt;
    logic [1:0]       quarter;      // master clock quarter
    logic [1:0]       next_quarter;
    logic [EW-1:0]    err_cnt;      // overrun pulse cycles left
    logic [EW-1:0]    next_err_cnt;
    logic [OVC_W-1:0] ovr_count;    // overruns seen, wraps
    logic [OVC_W-1:0] next_ovr_count;
    logic             sclk_prev;    // synced clock one cycle ago
    logic             next_sclk_prev;

    arp_pins_t        pins;         // registered data pins
    arp_pins_t        next_pins;

    // combinational helpers
    logic rd_en;       // host has both select and read low
    logic slave_edge;  // active external clock edge, gated by select
    logic reading;     // serial bits are being presented
    logic sclk_gen;    // internally made serial clock, before invert
    logic err_on;      // overrun pulse is running

    assign rd_en      = ~s_cs_n & ~s_rd_n;
    assign slave_edge = ~s_cs_n &
                        clk_edge(sclk_prev, s_sclk, cfg_act.clk_inv);
    assign reading    = (state == ST_MASTER) | (state == ST_SLAVE);
    assign sclk_gen   = (state == ST_MASTER) &
                        ((quarter == Q_RISE) | (quarter == Q_HIGH));
    assign err_on     = (err_cnt != '0);

    // status view for the bus
    always_comb begin
        status_word = '0;
        status_word[ST_BUSY_BIT] = busy;
        status_word[ST_READ_BIT] = (state != ST_IDLE);
        status_word[ST_ERR_BIT]  = err_on;
        status_word[ST_OVC_LSB +: OVC_W] = ovr_count;
    end

    // avalon slave: every access waits one cycle, then answers; read data
    // are caught in the waiting cycle so they stand at the answer edge
    always_comb begin
        next_ack   = (avs_read | avs_write) & ~ack;
        next_rdata = rdata;
        next_cfg   = cfg;
        next_div   = div;
        if (avs_read & ~ack) begin
            case (avs_address)
                ADDR_CONFIG:  next_rdata = 32'(cfg);
                ADDR_STATUS:  next_rdata = status_word;
                ADDR_RESULT:  next_rdata = 32'(result);
                ADDR_DIVIDER: next_rdata = 32'(div);
                default:      next_rdata = 32'h0;  // unmapped reads zero
            endcase
        end
        // a write lands only at the edge where waitrequest is low
        if (avs_write & ack) begin
            case (avs_address)
                ADDR_CONFIG:  next_cfg = arp_cfg_t'(avs_writedata[CFG_W-1:0]);
                ADDR_DIVIDER: next_div = avs_writedata[DIV_W-1:0];
                default:      ;  // read-only or unmapped: ignored
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack   <= 1'b0;
            rdata <= 32'h0;
            cfg   <= CFG_RESET;
            div   <= DIV_RESET;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
            cfg   <= next_cfg;
            div   <= next_div;
        end
    end

    assign avs_readdata    = rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    // conversion timing: a start edge while idle runs a fixed count, then
    // the coded core result is latched and busy falls in the same cycle
    always_comb begin
        next_busy      = busy;
        next_conv_cnt  = conv_cnt;
        next_result    = result;
        next_conv_done = 1'b0;
        if (busy) begin
            if (conv_cnt == '0) begin
                next_busy      = 1'b0;
                next_result    = code_result(sample_data,
                                             cfg.coding);
                next_conv_done = 1'b1;
            end else begin
                next_conv_cnt = conv_cnt - 1'b1;
            end
        end else if (cnv_prev & ~s_cnv_n) begin
            // start edges during a conversion are dropped
            next_busy     = 1'b1;
            next_conv_cnt = CONV_LAST;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy      <= 1'b0;
            conv_cnt  <= '0;
            result    <= '0;
            cnv_prev  <= 1'b1;
            conv_done <= 1'b0;
        end else begin
            busy      <= next_busy;
            conv_cnt  <= next_conv_cnt;
            result    <= next_result;
            cnv_prev  <= s_cnv_n;
            conv_done <= next_conv_done;
        end
    end

    // serial read sequencer
    always_comb begin
        next_state     = state;
        next_cfg_act   = cfg_act;
        next_shreg     = shreg;
        next_bit_cnt   = bit_cnt;
        next_div_cnt   = div_cnt;
        next_quarter   = quarter;
        next_err_cnt   = err_on ? err_cnt - 1'b1 : err_cnt;
        next_ovr_count = ovr_count;
        next_sclk_prev = s_sclk;
        case (state)
            ST_IDLE: begin
                // settings follow software only between reads
                next_cfg_act = cfg;
                next_shreg   = result;
                next_bit_cnt = '0;
                next_div_cnt = '0;
                next_quarter = Q_DATA;
                if (rd_en & cfg.ser_sel) begin
                    if (!cfg.clk_src) begin
                        // low timing select waits for the new result
                        if (cfg.rd_timing | ~busy) begin
                            next_state = ST_MASTER;
                        end
                    end else begin
                        next_state = ST_SLAVE;
                    end
                end
            end
            ST_MASTER: begin
                if (!rd_en) begin
                    // host let go: the read is abandoned
                    next_state = ST_IDLE;
                end else if (div_cnt == div) begin
                    next_div_cnt = '0;
                    next_quarter = 2'(quarter + 2'h1);
                    // data move at the end of the falling quarter, far
                    // from both edges, so both edges see stable data
                    if (quarter == Q_FALL) begin
                        next_shreg = {shreg[RES_W-2:0], 1'b0};
                        next_bit_cnt = bit_cnt + 1'b1;
                        if (bit_cnt == LAST_BIT) begin
                            next_state = ST_HOLD;
                        end
                    end
                end else begin
                    next_div_cnt = div_cnt + 1'b1;
                end
            end
            ST_SLAVE: begin
                if (conv_done) begin
                    // new result while unread: old data lost, flag pulsed
                    next_state     = ST_HOLD;
                    next_err_cnt   = ERR_LOAD;
                    next_ovr_count = ovr_count + 1'b1;
                end else if (slave_edge) begin
                    next_shreg   = {shreg[RES_W-2:0], 1'b0};
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt == LAST_BIT) begin
                        next_state = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // one read per select/read assertion
                if (!rd_en) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            cfg_act   <= CFG_RESET;
            shreg     <= '0;
            bit_cnt   <= '0;
            div_cnt   <= '0;
            quarter   <= Q_DATA;
            err_cnt   <= '0;
            ovr_count <= '0;
            sclk_prev <= 1'b0;
        end else begin
            state     <= next_state;
            cfg_act   <= next_cfg_act;
            shreg     <= next_shreg;
            bit_cnt   <= next_bit_cnt;
            div_cnt   <= next_div_cnt;
            quarter   <= next_quarter;
            err_cnt   <= next_err_cnt;
            ovr_count <= next_ovr_count;
            sclk_prev <= next_sclk_prev;
        end
    end

    // pin mux: everything floats unless the host selects and reads
    always_comb begin
        next_pins.out = '0;
        next_pins.oe  = '0;
        if (rd_en) begin
            if (!cfg_act.ser_sel) begin
                // parallel: whole word, pins 8..11 as plain bits
                next_pins.out = result;
                next_pins.oe  = '1;
            end else begin
                // serial: only pins 8..11 may drive; pins 0..7 and
                // 12..15 stay off
                next_pins.out[PIN_SDO]  = reading & shreg[RES_W-1];
                next_pins.out[PIN_SCLK] = sclk_gen ^ cfg_act.clk_inv;
                next_pins.out[PIN_SYNC] = (state == ST_MASTER) ^
                                          cfg_act.frame_pol;
                next_pins.out[PIN_ERR]  = cfg_act.clk_src ?
                                          err_on : result[PIN_ERR];
                next_pins.oe[PIN_SDO]   = 1'b1;
                next_pins.oe[PIN_SCLK]  = ~cfg_act.clk_src;
                next_pins.oe[PIN_SYNC]  = 1'b1;
                next_pins.oe[PIN_ERR]   = 1'b1;
            end
        end
    end

    // pins come from flops, so they lag the sequencer by one cycle;
    // data and clock move together, keeping their relation intact
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins <= '0;
        end else begin
            pins <= next_pins;
        end
    end

    assign d_out = pins.out;
    assign d_oe  = pins.oe;

endmodule // arp_readout_port

// [pkg/arp_pkg.sv]
// arp_pkg: constants, types and register map of the result readout port.
// assumes a 100 MHz system clock and a 16-bit conversion result.
package arp_pkg;

    // system clock rate in MHz
    localparam int CLK_MHZ      = 100;
    // conversion time of the converter core, ns (least time, rounds up)
    localparam int CONV_TIME_NS = 700;
    localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    // width of the incomplete-read pulse, ns (least time, rounds up)
    localparam int ERR_PULSE_NS = 40;
    localparam int ERR_CYCLES   = (ERR_PULSE_NS * CLK_MHZ + 999) / 1000;

    // widths
    localparam int RES_W = 16;
    localparam int DIV_W = 8;
    localparam int OVC_W = 8;
    localparam int CFG_W = 6;

    // register byte offsets on the avalon bus
    localparam logic [3:0] ADDR_CONFIG  = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_RESULT  = 4'h8;
    localparam logic [3:0] ADDR_DIVIDER = 4'hC;

    // status register bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_READ_BIT = 1;
    localparam int ST_ERR_BIT  = 2;
    localparam int ST_OVC_LSB  = 8;

    // data pin indices that carry serial functions
    localparam int PIN_SDO  = 8;
    localparam int PIN_SCLK = 9;
    localparam int PIN_SYNC = 10;
    localparam int PIN_ERR  = 11;

    // serial bit counter and master clock quarters
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [1:0] Q_DATA   = 2'h0;
    localparam logic [1:0] Q_RISE   = 2'h1;
    localparam logic [1:0] Q_HIGH   = 2'h2;
    localparam logic [1:0] Q_FALL   = 2'h3;

    // readout configuration, bit 0 is ser_sel
    typedef struct packed {
        logic rd_timing;  // master: 1 = previous result during conversion
        logic coding;     // 1 = two's complement, 0 = straight binary
        logic frame_pol;  // 1 = frame sync active low
        logic clk_inv;    // 1 = serial clock inverted
        logic clk_src;    // 1 = external (slave) clock
        logic ser_sel;    // 1 = serial, 0 = parallel
    } arp_cfg_t;

    // reset values
    localparam arp_cfg_t         CFG_RESET = 6'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h04;

    // data pin bundle
    typedef struct packed {
        logic [RES_W-1:0] out;
        logic [RES_W-1:0] oe;
    } arp_pins_t;

    // serial read sequencer states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_MASTER = 2'b01,
        ST_SLAVE  = 2'b10,
        ST_HOLD   = 2'b11
    } arp_rd_state_t;

endpackage

// [hdl/arp_sync.sv]
// arp_sync: two flip-flop synchroniser for a group of pin levels.
// assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/100ps
module arp_sync
    import arp_pkg::*;
#(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;       // first stage, read only by the second
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    // next values: plain shift through the two stages
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end

endmodule // arp_sync

// [sim/arp_readout_port_props.sv]
// arp_readout_port_props: checker on the port's pins.
// assumes it is bound into arp_readout_port and sees only its ports.
`timescale 1ns/100ps
module arp_readout_port_props
    import arp_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES  // conversion length, cycles
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // avalon slave
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    // host pins
    input wire logic        conversion_start_n,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        busy,
    input wire logic [15:0] d_out,
    input wire logic [15:0] d_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    arp_cfg_t   cfg_q;  // config shadow
    logic [7:0] run_q;  // busy run length
    wire        ser_m = cfg_q.ser_sel && !cfg_q.clk_src;  // serial master
    wire        ser_s = cfg_q.ser_sel && cfg_q.clk_src;   // serial slave
    // shadow follows completed writes only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
            run_q <= 8'h00;
        end else begin
            if (avs_write && !avs_waitrequest && avs_address == ADDR_CONFIG)
                cfg_q <= arp_cfg_t'(avs_writedata[CFG_W-1:0]);
            run_q <= busy ? run_q + 8'h01 : 8'h00;
        end
    end
    a_wait_one_cycle:
        assert property ((avs_read || avs_write) && avs_waitrequest
            |=> !avs_waitrequest) else $error("long wait");
    a_gate_select:
        assert property ((cs_n || rd_n) [*5] |-> d_oe == '0)
            else $error("oe unselected");
    a_par_all_pins:
        assert property ((!cfg_q.ser_sel) [*4] ##0 (d_oe != '0)
            |-> d_oe == '1) else $error("parallel oe");
    a_ser_float:
        assert property (cfg_q.ser_sel [*4]
            |-> d_oe[15:12] == '0 && d_oe[1:0] == '0)
            else $error("serial float");
    a_sclk_drive:
        assert property (ser_m [*4] ##0 d_oe[PIN_SDO] |-> d_oe[PIN_SCLK])
            else $error("master sclk off");
    a_sclk_listen:
        assert property (ser_s [*4] |-> !d_oe[PIN_SCLK])
            else $error("slave sclk on");
    a_master_stable:
        assert property (ser_m [*4] ##0 d_oe[PIN_SCLK]
            && $stable(d_oe[PIN_SCLK]) && $changed(d_out[PIN_SCLK])
            |-> $stable(d_out[PIN_SDO])) else $error("data on edge");
    a_start_busy:
        assert property ($fell(conversion_start_n) && !busy |-> ##[1:5] busy)
            else $error("busy late");
    a_busy_length:
        assert property ($fell(busy)
            |-> run_q >= CONV_LEN - 1 && run_q <= CONV_LEN + 1)
            else $error("busy length");
    c_master: cover property (ser_m && d_oe[PIN_SYNC]);
    c_slave: cover property (ser_s && d_oe[PIN_SDO]);
    c_overrun: cover property (ser_s && d_oe[PIN_ERR] && d_out[PIN_ERR]);
endmodule // arp_readout_port_props
bind arp_readout_port arp_readout_port_props #(.CONV_LEN(CONV_LEN)) u_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .busy(busy), .d_out(d_out), .d_oe(d_oe)
);

// [sim/arp_host_model.sv]
// arp_host_model: host that reads results over the port's pins.
// assumes pins settle in six cycles; sclk idles between frames.
`timescale 1ns/100ps
module arp_host_model
    import arp_pkg::*;
(
    // clock
    input  wire logic        sys_clk,
    // pins from the port
    input  wire logic [15:0] d_out,
    input  wire logic [15:0] d_oe,
    // pins to the port
    output logic             cs_n,
    output logic             rd_n,
    output logic             link_sclk_in
);
    initial {cs_n, rd_n, link_sclk_in} = 3'b110;
    // select and read move together
    task automatic select(input logic on, input int settle);
        @(posedge sys_clk);
        {cs_n, rd_n} <= {2{!on}};
        repeat (settle) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic read_par(output logic [15:0] w, output logic [31:0] oe);
        select(1'b1, 6);
        w = d_out;
        oe = 32'(d_oe);
        select(1'b0, 6);
    endtask
    // host clocks the link; sample at each inactive edge, half a clock period before the active one
    task automatic read_slave(input logic inv, output logic [15:0] w);
        link_sclk_in = inv;  // idle level, select still high
        select(1'b1, 6);
        #2;  // clear of clock edges
        for (int i = 0; i < 16; i++) begin
            w = {w[14:0], d_out[PIN_SDO]};
            #62.5 link_sclk_in = !inv;
            #62.5 link_sclk_in = inv;
        end
        select(1'b0, 6);
    endtask
    // port clocks the link; data taken at each sclk rise
    task automatic read_master(input logic pol, output logic [15:0] w,
                               output int bad);
        logic prev = 1'b0;
        int   n = 0;
        bad = 0;
        select(1'b1, 0);
        for (int k = 0; k < 2000 && n < 16; k++) begin
            @(negedge sys_clk);
            if (d_oe[PIN_SCLK] && d_out[PIN_SCLK] && !prev) begin
                w = {w[14:0], d_out[PIN_SDO]};
                if (d_out[PIN_SYNC] !== !pol) bad++;
                n++;
            end
            prev = d_oe[PIN_SCLK] && d_out[PIN_SCLK];
        end
        repeat (20) @(negedge sys_clk);
        if (n < 16 || d_out[PIN_SYNC] !== pol) bad++;
        select(1'b0, 6);
    endtask
endmodule // arp_host_model

// [sim/arp_readout_port_tb.sv]
// arp_readout_port_tb: register, parallel and serial read tests.
// assumes an 8-cycle conversion and a one-cycle overrun pulse.
`timescale 1ns/100ps
module arp_readout_port_tb;
    import arp_pkg::*;
    logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] sample_data, d_out, d_oe;
    logic        conversion_start_n, cs_n, rd_n, link_sclk_in, busy;
    logic        err_seen;  // overrun pin seen high
    int          bad_count = 0;
    int          checks_done = 0;
    arp_readout_port #(.CONV_LEN(8), .ERR_LEN(1)) u_arp_readout_port (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sample_data(sample_data),
        .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
        .link_sclk_in(link_sclk_in), .busy(busy), .d_out(d_out),
        .d_oe(d_oe));
    arp_host_model u_arp_host_model (.sys_clk(sys_clk), .d_out(d_out),
        .d_oe(d_oe), .cs_n(cs_n), .rd_n(rd_n), .link_sclk_in(link_sclk_in));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) err_seen |= d_oe[PIN_ERR] & d_out[PIN_ERR];
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one avalon access, held until waitrequest is low at an edge
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
        if (n == 20) begin
            bad_count++;
            conclude();
        end
    endtask
    task automatic rchk(input string what, input logic [3:0] a,
                        input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask
    // start pulse; busy fall taken as data ready
    task automatic convert(input logic [15:0] s);
        int n;
        @(posedge sys_clk);
        sample_data <= s;
        conversion_start_n <= 1'b0;
        @(posedge sys_clk);
        conversion_start_n <= 1'b1;
        for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge sys_clk);
        for (; n < 40 && busy !== 1'b0; n++) @(negedge sys_clk);
        chk("busy cycle", 32'(n < 40), 32'h1);
        if (n == 40) conclude();
    endtask
    initial begin
        logic [31:0] q;
        logic [15:0] w;
        int          bad;
        {avs_read, avs_write, avs_address, avs_writedata, sample_data} = '0;
        {conversion_start_n, err_seen, rst_n} = 3'b100;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rchk("config", ADDR_CONFIG, 32'h0);
        rchk("divider", ADDR_DIVIDER, 32'h4);
        bus(1'b1, ADDR_STATUS, 32'hFFFFFFFF, q);
        rchk("status", ADDR_STATUS, 32'h0);
        rchk("unmapped", 4'h2, 32'h0);
        $display("registers done");
        convert(16'hA5C3);
        rchk("result", ADDR_RESULT, 32'hA5C3);
        u_arp_host_model.read_par(w, q);
        chk("par word", 32'(w), 32'hA5C3);
        chk("par oe", q, 32'hFFFF);
        bus(1'b1, ADDR_CONFIG, 32'h10, q);
        convert(16'h1234);
        u_arp_host_model.read_par(w, q);
        chk("par coded", 32'(w), 32'h9234);
        $display("parallel done");
        bus(1'b1, ADDR_DIVIDER, 32'h2, q);
        bus(1'b1, ADDR_CONFIG, 32'h09, q);
        convert(16'hC35A);
        u_arp_host_model.read_master(1'b1, w, bad);
        chk("master word", 32'(w), 32'hC35A);
        chk("master sync", 32'(bad), 32'h0);
        $display("master done");
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, ADDR_CONFIG, {29'h0, i[0], 2'h3}, q);
            convert(16'h5AC3 + 16'(i));
            u_arp_host_model.read_slave(i[0], w);
            chk("slave word", 32'(w), 32'h5AC3 + 32'(i));
        end
        $display("slave done");
        bus(1'b1, ADDR_CONFIG, 32'h3, q);
        err_seen = 1'b0;
        u_arp_host_model.select(1'b1, 6);
        convert(16'h0F0F);
        repeat (4) @(posedge sys_clk);
        chk("overrun pin", 32'(err_seen), 32'h1);
        u_arp_host_model.select(1'b0, 6);
        rchk("overrun count", ADDR_STATUS, 32'h100);
        $display("test overrun done");
        conclude();
    end
endmodule // arp_readout_port_tb
